// ---- hw/timing_hit_event_builder.sv ----
/*
 * Hit event builder: per-channel FIFOs, aggregation FIFO, frame builder,
 * scrambled 64b/66b coder, 66:64 gearbox, serializer word ordering,
 * PRBS15 self-test source, converter clock divider, serial config port.
 * Assumes clk_sys is the 320 MHz clock from the serializer PLL and that
 * the analog mux tree and 5.12 GHz driver take lineWord on lineStrobe.
 */
// Functional notes
// - Hits from all eight converter channels merge into one shared path.
// - All builder logic runs on the 320 MHz clock from the serializer.
// - Results leave as 64-bit parallel words at 160 Mbps.
// - Hits go into per-channel FIFOs, then into an aggregation FIFO.
// - A frame builder reads the FIFOs and hands frames to the coder.
// - Frames are 64b/66b coded with the 10GbE scrambler for DC balance.
// - A gearbox packs 66-bit blocks into 64-bit words losslessly.
// - Words go through 16:4, then 4:1, then a final mux to one line.
// - A PRBS15 source can replace the data for link self-test.
// - The serial line runs at 10.24 Gbps for the receiver to recover.
// - The PLL feeds 5.12 GHz to the serializer; the builder divides 320 MHz down to 40 MHz for converters.
// - Configuration of up to 200 bits loads over a serial port.
// - Each hit carries two recorder snapshots of fine and coarse times.
`timescale 1ns/1ns

module hit_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	output logic      [WIDTH-1:0] outData,
	input  wire logic             outReady
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wrReg, wrNext, rdReg, rdNext;
	logic [PW:0]      countReg, countNext;
	logic             readyReg, readyNext, validReg, validNext;
	logic             push, pop;

	function automatic logic [PW-1:0] wrap(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// pointer and fill bookkeeping; flags registered for clean outputs
	always_comb begin
		push      = inValid & readyReg;
		pop       = validReg & outReady;
		wrNext    = push ? wrap(wrReg) : wrReg;
		rdNext    = pop ? wrap(rdReg) : rdReg;
		countNext = countReg + (PW+1)'(push) - (PW+1)'(pop);
		readyNext = countNext != (PW+1)'(DEPTH);
		validNext = countNext != '0;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wrReg    <= '0;
			rdReg    <= '0;
			countReg <= '0;
			readyReg <= 1'b0;
			validReg <= 1'b0;
		end else begin
			wrReg    <= wrNext;
			rdReg    <= rdNext;
			countReg <= countNext;
			readyReg <= readyNext;
			validReg <= validNext;
		end
	end

	// storage has no reset; only written words are ever read
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wrReg] <= inData;
		end
	end

	assign inReady  = readyReg;
	assign outValid = validReg;
	assign outData  = mem[rdReg];
endmodule

module timing_hit_event_builder (
	input  wire logic                                      clk_sys,
	input  wire logic                                      rst,
	input  wire logic                 [timing_hit_pkg::CHANNELS-1:0] hitValid,
	input  timing_hit_pkg::hit_type   [timing_hit_pkg::CHANNELS-1:0] hitData,
	output logic                      [timing_hit_pkg::CHANNELS-1:0] hitReady,
	output logic                      [63:0]               lineWord,
	output logic                                           lineStrobe,
	output logic                                           converterClk,
	input  wire logic                                      spiClk,
	input  wire logic                                      spiSelect_n,
	input  wire logic                                      spiDataIn,
	output logic                                           spiDataOut
);
	import timing_hit_pkg::*;

	typedef struct packed {
		logic [57:0] state;
		logic [63:0] data;
	} scr_type;

	typedef struct packed {
		logic [14:0] state;
		logic [63:0] data;
	} prbs_type;

	// self-synchronous scrambler, one bit per payload position
	function automatic scr_type scramble(input logic [57:0] s,
		input logic [63:0] d);
		scr_type r;
		logic    b;
		r.state = s;
		r.data  = '0;
		for (int i = 0; i < 64; i++) begin
			b         = d[i] ^ r.state[SCR_TAP_A] ^ r.state[SCR_TAP_B];
			r.data[i] = b;
			r.state   = {r.state[56:0], b};
		end
		return r;
	endfunction

	// x^15 + x^14 + 1, 64 bits per line word
	function automatic prbs_type prbs15(input logic [14:0] s);
		prbs_type r;
		logic     b;
		r.state = s;
		r.data  = '0;
		for (int i = 0; i < 64; i++) begin
			b         = r.state[PRBS_TAP_A] ^ r.state[PRBS_TAP_B];
			r.data[i] = b;
			r.state   = {r.state[13:0], b};
		end
		return r;
	endfunction

	// mux tree order: line bit t from 16:4 unit t%4, slot t/4
	function automatic logic [63:0] muxOrder(input logic [63:0] w);
		logic [63:0] r;
		r = '0;
		for (int t = 0; t < 64; t++) begin
			r[t] = w[16 * (t % 4) + (t / 4)];
		end
		return r;
	endfunction

	// first level: one FIFO per channel, gated by channel enable
	logic    [CHANNELS-1:0] l1Valid, l1Ready, l1Push;
	hit_type [CHANNELS-1:0] l1Data;
	logic    [CFG_BITS-1:0] cfgReg, cfgNext, shiftReg, shiftNext;

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_l1
			assign l1Push[ch] = hitValid[ch] & cfgReg[CFG_ENABLE_POS + ch];
			hit_fifo #(.WIDTH($bits(hit_type)), .DEPTH(FIFO_DEPTH)) u_l1 (
				.clk_sys  (clk_sys),
				.rst      (rst),
				.inValid  (l1Push[ch]),
				.inData   (hitData[ch]),
				.inReady  (hitReady[ch]),
				.outValid (l1Valid[ch]),
				.outData  (l1Data[ch]),
				.outReady (l1Ready[ch])
			);
		end
	endgenerate

	// round-robin merge of channels into the aggregation FIFO
	logic [2:0]  rrReg, rrNext, pick, idx;
	logic        found, l2InReady, l2Push, l2Valid, l2Ready;
	logic [7:0]  bunchReg, bunchNext;
	frame_type   l2In, l2Out;

	always_comb begin
		found   = 1'b0;
		pick    = rrReg;
		idx     = rrReg;
		l1Ready = '0;
		for (int k = 0; k < CHANNELS; k++) begin
			idx = rrReg + 3'(k + 1);
			if (!found && l1Valid[idx]) begin
				found = 1'b1;
				pick  = idx;
			end
		end
		l2Push        = found & l2InReady;
		l1Ready[pick] = l2Push;
		rrNext        = l2Push ? pick : rrReg;
		l2In.bunch    = bunchReg;
		l2In.channel  = pick;
		l2In.spare    = '0;
		l2In.hit      = l1Data[pick];
	end

	// second level: aggregated frame words wait for the gearbox
	hit_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_l2 (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.inValid  (l2Push),
		.inData   (l2In),
		.inReady  (l2InReady),
		.outValid (l2Valid),
		.outData  (l2Out),
		.outReady (l2Ready)
	);

	// frame builder, coder, gearbox and serializer word path
	logic        slotReg, slotNext, take;
	logic [6:0]  leftReg, leftNext;
	logic [63:0] spillReg, spillNext, gearWord, lineNext;
	logic [57:0] scrReg, scrNext;
	logic [14:0] prbsReg, prbsNext;
	logic        strobeNext;
	logic [129:0] joined;
	block_type   block;
	scr_type     scr;
	prbs_type    prbs;

	always_comb begin
		slotNext   = ~slotReg; // one word per WORD_DIV cycles
		take       = slotReg && (leftReg < 7'(WORD_BITS));
		l2Ready    = take & l2Valid;
		block.sync = l2Valid ? SYNC_DATA : SYNC_CTRL;
		scr        = scramble(scrReg, l2Valid ? l2Out
			: {56'h0, IDLE_TYPE});
		block.payload = scr.data;
		scrNext    = take ? scr.state : scrReg;
		joined     = {66'h0, spillReg} | ({64'h0, block} << leftReg);
		gearWord   = spillReg;
		spillNext  = spillReg;
		leftNext   = leftReg;
		if (take) begin
			gearWord  = joined[63:0];
			spillNext = joined[127:64];
			leftNext  = leftReg + 7'h2;
		end else if (slotReg) begin
			spillNext = '0; // full spill word drains, no block taken
			leftNext  = '0;
		end
		prbs       = prbs15(prbsReg);
		prbsNext   = slotReg ? prbs.state : prbsReg;
		lineNext   = lineWord;
		if (slotReg) begin
			lineNext = muxOrder(cfgReg[CFG_PRBS_POS] ? prbs.data
				: gearWord);
		end
		strobeNext = slotReg;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rrReg      <= '0;
			slotReg    <= 1'b0;
			leftReg    <= '0;
			spillReg   <= '0;
			scrReg     <= SCR_SEED;
			prbsReg    <= PRBS_SEED;
			lineWord   <= '0;
			lineStrobe <= 1'b0;
		end else begin
			rrReg      <= rrNext;
			slotReg    <= slotNext;
			leftReg    <= leftNext;
			spillReg   <= spillNext;
			scrReg     <= scrNext;
			prbsReg    <= prbsNext;
			lineWord   <= lineNext;
			lineStrobe <= strobeNext;
		end
	end

	// converter clock and bunch count; 40 MHz derived, free-running from reset
	logic [2:0] convCntReg, convCntNext;
	logic       convClkNext;

	always_comb begin
		convCntNext = convCntReg + 3'h1;
		convClkNext = converterClk;
		bunchNext   = bunchReg;
		if (convCntReg == 3'(CONV_HALF - 1)) begin
			convCntNext = '0;
			convClkNext = ~converterClk;
			bunchNext   = converterClk ? bunchReg : bunchReg + 8'h1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			convCntReg   <= '0;
			converterClk <= 1'b0;
			bunchReg     <= '0;
		end else begin
			convCntReg   <= convCntNext;
			converterClk <= convClkNext;
			bunchReg     <= bunchNext;
		end
	end

	// serial config: pins sampled on clk_sys, so spiClk must be slow
	logic spiClkReg, spiSelReg, spiOutNext;

	always_comb begin
		shiftNext  = shiftReg;
		cfgNext    = cfgReg;
		spiOutNext = spiDataOut;
		if (!spiSelect_n && spiClk && !spiClkReg) begin
			shiftNext  = {shiftReg[CFG_BITS-2:0], spiDataIn};
			spiOutNext = shiftReg[CFG_BITS-1];
		end
		if (spiSelect_n && !spiSelReg) begin
			cfgNext = shiftReg; // apply only at end of frame
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			spiClkReg  <= 1'b0;
			spiSelReg  <= 1'b1;
			shiftReg   <= CFG_RESET;
			cfgReg     <= CFG_RESET;
			spiDataOut <= 1'b0;
		end else begin
			spiClkReg  <= spiClk;
			spiSelReg  <= spiSelect_n;
			shiftReg   <= shiftNext;
			cfgReg     <= cfgNext;
			spiDataOut <= spiOutNext;
		end
	end
endmodule

// ---- hw/timing_hit_pkg.sv ----
/*
 * Shared constants and carrier types for the timing hit event builder.
 * Assumes one 320 MHz builder clock supplied by the serializer side.
 */
package timing_hit_pkg;
	// channel count and buffering
	localparam int CHANNELS       = 8;
	localparam int FIFO_DEPTH     = 4;
	localparam int WORD_BITS      = 64;
	// rates in their own units
	localparam int BUILD_CLK_MHZ  = 320;
	localparam int WORD_RATE_MBPS = 160;
	localparam int LINE_RATE_MBPS = 10240;
	localparam int SER_CLK_MHZ    = 5120;
	localparam int CONV_CLK_MHZ   = 40;
	// cycle counts and a line rate check derived from the rates
	localparam int WORD_DIV       = BUILD_CLK_MHZ / WORD_RATE_MBPS;
	localparam int CONV_HALF      = BUILD_CLK_MHZ / CONV_CLK_MHZ / 2;
	localparam int LINE_CHECK     = WORD_RATE_MBPS * WORD_BITS;
	// block coding
	localparam logic [1:0]  SYNC_DATA  = 2'h1;
	localparam logic [1:0]  SYNC_CTRL  = 2'h2;
	localparam logic [7:0]  IDLE_TYPE  = 8'h1E;
	localparam logic [57:0] SCR_SEED   = 58'h3FFFFFFFFFFFFFF;
	localparam int          SCR_TAP_A  = 38;
	localparam int          SCR_TAP_B  = 57;
	localparam logic [14:0] PRBS_SEED  = 15'h7FFF;
	localparam int          PRBS_TAP_A = 14;
	localparam int          PRBS_TAP_B = 13;
	// serial configuration
	localparam int           CFG_BITS       = 200;
	localparam int           CFG_PRBS_POS   = 0;
	localparam int           CFG_ENABLE_POS = 1;
	localparam logic [199:0] CFG_RESET      = 200'h1FE;

	// one snapshot of a recorder chain
	typedef struct packed {
		logic [3:0] calibCoarse;
		logic [3:0] calibFine;
		logic [3:0] totCoarse;
		logic [3:0] totFine;
		logic [3:0] arrivalCoarse;
		logic [4:0] arrivalFine;
	} capture_type;

	// both snapshots of one hit
	typedef struct packed {
		capture_type second;
		capture_type first;
	} hit_type;

	// aggregated 64-bit frame word
	typedef struct packed {
		logic [7:0] bunch;
		logic [2:0] channel;
		logic [2:0] spare;
		hit_type    hit;
	} frame_type;

	// one 66-bit coded block, sync header in the low bits
	typedef struct packed {
		logic [63:0] payload;
		logic [1:0]  sync;
	} block_type;
endpackage

// ---- test/timing_hit_checker.sv ----
/*
 * Port-level checks for the event builder: line cadence, converter clock,
 * hit ready behaviour.
 * Assumes a bind onto the top module and the single clk_sys domain.
 */
`timescale 1ns/1ns
module timing_hit_checker
	import timing_hit_pkg::*;
(
	input wire logic                clk_sys,
	input wire logic                rst,
	input wire logic [CHANNELS-1:0] hitValid,
	input wire logic [CHANNELS-1:0] hitReady,
	input wire logic [63:0]         lineWord,
	input wire logic                lineStrobe,
	input wire logic                converterClk
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	// line words leave one every two cycles
	a_strobe_gap: assert property (lineStrobe |=> !lineStrobe)
		else $error("strobe longer than one cycle");
	a_strobe_period: assert property (lineStrobe |-> ##2 lineStrobe)
		else $error("strobe period not two cycles");
	a_word_hold: assert property (!lineStrobe |-> $stable(lineWord))
		else $error("line word moved without strobe");
	// 40 MHz is four high and four low builder cycles
	a_conv_high: assert property ($rose(converterClk) |->
		converterClk [*4] ##1 !converterClk)
		else $error("converter clock high phase wrong");
	a_conv_low: assert property ($fell(converterClk) |->
		!converterClk [*4] ##1 converterClk)
		else $error("converter clock low phase wrong");
	a_conv_reset: assert property ($fell(rst) |-> !converterClk)
		else $error("converter clock high after reset");
	// ready only falls when something was offered
	a_ready_release: assert property ($fell(rst) |->
		hitReady == '0 ##1 hitReady == '1)
		else $error("ready not raised after reset");
	a_ready_drop: assert property
		(($past(hitReady) & ~hitReady & ~$past(hitValid)) == '0)
		else $error("ready fell without a hit");

	c_strobe: cover property (lineStrobe);
	c_take: cover property (hitValid[0] && hitReady[0]);
	c_full: cover property (hitValid != '0 && hitReady != '1);
endmodule

// ---- test/line_receiver.sv ----
/*
 * Back-end receiver model: undoes the mux order, walks the 66-bit blocks,
 * descrambles and checks the self-test sequence.
 * Assumes block alignment starts at bit 0 of the first word after reset.
 */
`timescale 1ns/1ns
module line_receiver
	import timing_hit_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [63:0] lineWord,
	input wire logic        lineStrobe,
	input wire logic        prbsCheck,
	output logic     [1:0]  rxSync,
	output logic     [63:0] rxPayload,
	output int              rxCount,
	output int              prbsErr
);
	logic [63:0] gear;
	logic [63:0] pl;
	logic [57:0] scr;
	logic [14:0] hist;
	logic [1:0]  sy;
	logic        b;
	int          pos;
	int          seen;

	// one word per strobe, handled bit by bit in word order after undoing the mux order
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pos = 0;
			seen = 0;
			scr = SCR_SEED;
			rxCount = 0;
			prbsErr = 0;
		end else if (lineStrobe) begin
			for (int t = 0; t < 64; t++)
				gear[16 * (t % 4) + t / 4] = lineWord[t];
			for (int i = 0; i < 64; i++) begin
				b = gear[i];
				// self-synchronous: state takes the received bit
				if (pos < 2) begin
					sy[pos] = b;
				end else begin
					pl[pos - 2] = b ^ scr[38] ^ scr[57];
					scr = {scr[56:0], b};
				end
				pos++;
				if (pos == 66) begin
					pos = 0;
					rxSync = sy;
					rxPayload = pl;
					rxCount++;
				end
				// sequence check needs 15 bits of history first
				if (!prbsCheck)
					seen = 0;
				else if (seen++ >= 15 && b !== (hist[14] ^ hist[13]))
					prbsErr++;
				hist = {hist[13:0], b};
			end
		end
	end
endmodule

// ---- test/timing_hit_event_builder_tb.sv ----
/*
 * Bench for the event builder: hits offered on all channels, line decoded
 * by the receiver model, configuration loaded over the serial port.
 * Assumes the checker and receiver files are compiled first.
 */
`timescale 1ns/1ns
module timing_hit_event_builder_tb;
	import timing_hit_pkg::*;
	logic                  clk_sys, rst, lineStrobe, converterClk;
	logic                  spiClk, spiSelect_n, spiDataIn, prbsCheck;
	logic                  spiDataOut;
	logic [CHANNELS-1:0]   hitValid, hitReady;
	hit_type [CHANNELS-1:0] hitData;
	logic [63:0]           lineWord, rxPayload;
	logic [1:0]            rxSync;
	logic                  chkOn, full;
	int                    rxCount, prbsErr, nFail, checkCount, cyc, nData;
	int                    sent[CHANNELS], got[CHANNELS];
	frame_type             fr;
	logic [CFG_BITS-1:0]   lastCfg = CFG_RESET;

	timing_hit_event_builder u_dut (.clk_sys(clk_sys), .rst(rst),
		.hitValid(hitValid), .hitData(hitData), .hitReady(hitReady),
		.lineWord(lineWord), .lineStrobe(lineStrobe),
		.converterClk(converterClk), .spiClk(spiClk),
		.spiSelect_n(spiSelect_n), .spiDataIn(spiDataIn),
		.spiDataOut(spiDataOut));
	line_receiver u_rx (.clk_sys(clk_sys), .rst(rst), .lineWord(lineWord),
		.lineStrobe(lineStrobe), .prbsCheck(prbsCheck), .rxSync(rxSync),
		.rxPayload(rxPayload), .rxCount(rxCount), .prbsErr(prbsErr));

	function automatic hit_type mk(input int c, input int n);
		return hit_type'(50'((c << 8) + n));
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checkCount++;
		if (seen !== exp) begin
			nFail++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d failures %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// every decoded block: data in sequence within its channel, else an idle
	always @(rxCount) begin
		if (chkOn && rxCount > 0) begin
			if (rxSync === SYNC_DATA) begin
				fr = frame_type'(rxPayload);
				check(64'(fr.hit), 64'(mk(fr.channel, got[fr.channel])));
				got[fr.channel]++;
				nData++;
			end else
				check(64'({rxSync, rxPayload[7:0]}),
					64'({SYNC_CTRL, IDLE_TYPE}));
		end
	end

	// offer hits on masked channels until each has sent lim
	task automatic drive(input logic [7:0] mask, input int lim, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			for (int c = 0; c < CHANNELS; c++) begin
				if (hitValid[c] && hitReady[c])
					sent[c]++;
				hitValid[c] <= mask[c] && sent[c] < lim;
				hitData[c] <= mk(c, sent[c]);
			end
			if ((hitValid & ~hitReady) != '0)
				full = 1'h1;
		end
		// one more edge so the last offer is counted, then withdraw
		@(posedge clk_sys);
		for (int c = 0; c < CHANNELS; c++)
			sent[c] += int'(hitValid[c] && hitReady[c]);
		hitValid <= '0;
	endtask

	// most significant bit first, clock phases two cycles each;
	// the previous frame comes back on spiDataOut, one bit per rise
	task automatic load(input logic [CFG_BITS-1:0] cfg);
		logic [CFG_BITS-1:0] back;
		back = '0;
		spiSelect_n <= 1'h0;
		for (int i = CFG_BITS - 1; i >= 0; i--) begin
			repeat (2) @(posedge clk_sys);
			if (i < CFG_BITS - 1)
				back = {back[CFG_BITS-2:0], spiDataOut};
			spiDataIn <= cfg[i];
			spiClk <= 1'h0;
			repeat (2) @(posedge clk_sys);
			spiClk <= 1'h1;
		end
		repeat (2) @(posedge clk_sys);
		back = {back[CFG_BITS-2:0], spiDataOut};
		check(64'(back !== lastCfg), 64'(0));
		lastCfg = cfg;
		spiSelect_n <= 1'h1;
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic t_idle();
		int   r = 0;
		logic prev;
		prev = converterClk;
		repeat (80) begin
			@(posedge clk_sys);
			r += int'(converterClk && !prev);
			prev = converterClk;
		end
		check(64'(r), 64'(10));
		check(64'(rxCount >= 30), 64'(1));
		$display("idle stream done");
	endtask

	task automatic t_burst();
		full = 1'h0;
		drive(8'hFF, 6, 150);
		repeat (200) @(posedge clk_sys);
		check(64'(nData), 64'(48));
		check(64'(full), 64'(1));
		$display("burst done");
	endtask

	task automatic t_disable();
		int n0 = nData;
		load(CFG_RESET & ~(200'h1 << 3));
		drive(8'h04, sent[2] + 4, 40);
		repeat (60) @(posedge clk_sys);
		check(64'(nData), 64'(n0));
		got[2] = sent[2];
		load(CFG_RESET);
		drive(8'h04, sent[2] + 2, 20);
		repeat (60) @(posedge clk_sys);
		check(64'(nData), 64'(n0 + 2));
		$display("channel enable done");
	endtask

	task automatic t_prbs();
		chkOn = 1'h0;
		load(CFG_RESET | 200'h1);
		repeat (16) @(posedge clk_sys);
		prbsCheck <= 1'h1;
		repeat (200) @(posedge clk_sys);
		check(64'(prbsErr), 64'(0));
		$display("self-test source done");
	endtask

	// builder clock
	initial begin
		clk_sys = 1'h0;
		forever #10 clk_sys = ~clk_sys;
	end

	// hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 9000) begin
			nFail++;
			end_of_test();
		end
	end

	initial begin
		rst = 1'h1;
		hitValid = '0;
		hitData = '0;
		spiClk = 1'h0;
		spiSelect_n = 1'h1;
		spiDataIn = 1'h0;
		prbsCheck = 1'h0;
		chkOn = 1'h1;
		repeat (5) @(posedge clk_sys);
		rst <= 1'h0;
		t_idle();
		t_burst();
		t_disable();
		t_prbs();
		end_of_test();
	end
endmodule

bind timing_hit_event_builder timing_hit_checker u_chk (.clk_sys(clk_sys),
	.rst(rst), .hitValid(hitValid), .hitReady(hitReady),
	.lineWord(lineWord), .lineStrobe(lineStrobe),
	.converterClk(converterClk));
